//--- tmr_ctrl.sv
/*
  8-bit timer/counter with clock select, force-compare strobes, counter
  access, two compare channels and overflow/compare flags.
  Assumes a single-cycle strobe register bus on core_clk and that the
  external count pin is asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Force strobes act only in non-PWM waveform modes; ignored in PWM modes.
// - A force strobe applies the channel's current output action immediately.
// - Forced compare sets no flag and never clears the counter.
// - Force bits are write-only and always read zero.
// - Reserved control B bits 5:4 and mask/flag bits 7..3 read zero.
// - Clock select: 0 stop, 1 undivided, 2..5 prescale by 8/64/256/1024.
// - Code 6 counts falling pin edges, code 7 rising pin edges.
// - Pin edges count even when the pin is used as an output.
// - Software reads and writes the 8-bit counter directly.
// - Counter write blocks compare matches on the next timer tick.
// - Each compare register continuously compared; match drives flag and output.
// - Control B bit 3 holds the waveform mode's most significant bit.
// - Enables at bits 2,1,0; request needs enable, flag and global bit.
// - Compare B flag sets on counter match with compare B.
// - Compare A flag sets on counter match with compare A.
// - Flags clear when the processor executes the matching vector.
// - Writing one clears a flag; writing zero leaves it.
// - Overflow flag sets on overflow, position depending on waveform mode.
// - Overflow at 0xFF in modes 0,2,3; bottom in 1,5; top in 7.
// - Output actions: 00 off, 01 toggle, 10 clear, 11 set.
module tmr_ctrl
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External count pin
  input wire logic ext_count_clock_pin,
  // Interrupt side
  input wire logic cpu_global_irq_en,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  // Waveform outputs
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_en_a,
  output logic wave_en_b
);

  logic [7:0] timer_control_a;
  logic [2:0] clock_source_sel;
  logic wave_mode_msb;
  logic [7:0] timer_count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [2:0] timer_irq_enable;
  logic [2:0] timer_irq_pending;
  logic [PRE_W-1:0] prescale;
  logic [2:0] pin_sync;
  logic pin_level;
  logic count_up;
  logic match_block;

  wire logic [2:0] wave_mode_sel = {wave_mode_msb, timer_control_a[1:0]};
  wire logic [1:0] out_action_a = timer_control_a[OUTA_LSB+1:OUTA_LSB];
  wire logic [1:0] out_action_b = timer_control_a[OUTB_LSB+1:OUTB_LSB];
  wire logic pwm_mode = (wave_mode_sel == WM_PC_FF) || (wave_mode_sel == WM_FAST_FF) ||
    (wave_mode_sel == WM_PC_TOPA) || (wave_mode_sel == WM_FAST_TOPA);
  wire logic wr_ctrl_a = reg_wr && (reg_addr == OFS_CTRL_A);
  wire logic wr_ctrl_b = reg_wr && (reg_addr == OFS_CTRL_B);
  wire logic wr_count = reg_wr && (reg_addr == OFS_COUNT);
  wire logic wr_pend = reg_wr && (reg_addr == OFS_IRQ_PEND);

  // Force strobes, honoured only outside PWM modes
  wire logic force_a = wr_ctrl_b && reg_wdata[FOC_A_BIT] && !pwm_mode;
  wire logic force_b = wr_ctrl_b && reg_wdata[FOC_B_BIT] && !pwm_mode;

  // Free-running prescaler
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // Three-stage pin synchroniser; edges judged from stages two and three
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_sync <= 3'b000;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], ext_count_clock_pin};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
      end
    end
  end
  wire logic pin_stable = (pin_sync[1] == pin_sync[2]);
  wire logic pin_rise = pin_stable && pin_sync[2] && !pin_level;
  wire logic pin_fall = pin_stable && !pin_sync[2] && pin_level;

  // Timer tick from the selected source
  always_comb begin
    unique case (clock_source_sel)
      CS_STOP: count_up = 1'b0;
      CS_DIV1: count_up = 1'b1;
      CS_DIV8: count_up = (prescale[2:0] == 3'h7);
      CS_DIV64: count_up = (prescale[5:0] == 6'h3f);
      CS_DIV256: count_up = (prescale[7:0] == 8'hff);
      CS_DIV1024: count_up = (prescale == 10'h3ff);
      CS_EXT_FALL: count_up = pin_fall;
      CS_EXT_RISE: count_up = pin_rise;
    endcase
  end

  // Counter direction and top for each mode
  logic count_down;
  logic [7:0] top_value;
  always_comb begin
    top_value = CNT_MAX;
    if (wave_mode_sel == WM_CTC || wave_mode_sel == WM_PC_TOPA || wave_mode_sel == WM_FAST_TOPA) begin
      top_value = compare_value_a;
    end
  end
  wire logic phase_mode = (wave_mode_sel == WM_PC_FF) || (wave_mode_sel == WM_PC_TOPA);
  wire logic at_top = (timer_count_value == top_value);
  wire logic match_a = count_up && !match_block && (timer_count_value == compare_value_a);
  wire logic match_b = count_up && !match_block && (timer_count_value == compare_value_b);

  // Overflow event position per mode
  logic ovf_evt;
  always_comb begin
    unique case (wave_mode_sel)
      WM_PC_FF, WM_PC_TOPA: ovf_evt = count_up && count_down && (timer_count_value == CNT_BOTTOM + 8'h01);
      WM_FAST_TOPA: ovf_evt = count_up && at_top;
      default: ovf_evt = count_up && (timer_count_value == CNT_MAX);
    endcase
  end

  // Counter: software write wins, else counts on tick; force never clears
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer_count_value <= RST_REG;
      count_down <= 1'b0;
    end else if (wr_count) begin
      timer_count_value <= reg_wdata;
    end else if (count_up) begin
      if (phase_mode) begin
        if (count_down && timer_count_value == CNT_BOTTOM + 8'h01) begin
          count_down <= 1'b0;
        end else if (!count_down && timer_count_value == top_value - 8'h01) begin
          count_down <= 1'b1;
        end
        timer_count_value <= count_down ? timer_count_value - 8'h01 : timer_count_value + 8'h01;
      end else if (at_top && wave_mode_sel != WM_NORMAL) begin
        timer_count_value <= CNT_BOTTOM;
      end else begin
        timer_count_value <= timer_count_value + 8'h01;
      end
    end
  end

  // Match blocking across the next timer tick after a counter write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      match_block <= 1'b0;
    end else if (wr_count) begin
      match_block <= 1'b1;
    end else if (count_up) begin
      match_block <= 1'b0;
    end
  end

  // Control, compare and enable registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer_control_a <= RST_REG;
      clock_source_sel <= CS_STOP;
      wave_mode_msb <= 1'b0;
      compare_value_a <= RST_REG;
      compare_value_b <= RST_REG;
      timer_irq_enable <= 3'b000;
    end else if (reg_wr) begin
      if (wr_ctrl_a) begin
        timer_control_a <= reg_wdata;
      end
      if (wr_ctrl_b) begin
        clock_source_sel <= reg_wdata[2:0];
        wave_mode_msb <= reg_wdata[WGM_MSB_BIT];
      end
      if (reg_addr == OFS_CMP_A) begin
        compare_value_a <= reg_wdata;
      end
      if (reg_addr == OFS_CMP_B) begin
        compare_value_b <= reg_wdata;
      end
      if (reg_addr == OFS_IRQ_EN) begin
        timer_irq_enable <= reg_wdata[2:0];
      end
    end
  end

  // Flags: hardware set wins over ack and write-one clear
  wire logic [2:0] flag_set = {match_b, match_a, ovf_evt};
  wire logic [2:0] flag_clr = irq_ack | (wr_pend ? reg_wdata[2:0] : 3'b000);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer_irq_pending <= 3'b000;
    end else begin
      timer_irq_pending <= flag_set | (timer_irq_pending & ~flag_clr);
    end
  end

  // Interrupt requests
  assign irq_req = cpu_global_irq_en ? (timer_irq_enable & timer_irq_pending) : 3'b000;

  // Waveform outputs: non-PWM action on match or force
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    unique case (act)
      OA_OFF: apply_action = cur;
      OA_TOGGLE: apply_action = !cur;
      OA_CLEAR: apply_action = 1'b0;
      OA_SET: apply_action = 1'b1;
    endcase
  endfunction : apply_action

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else if (!pwm_mode) begin
      if (force_a || match_a) begin
        wave_out_a <= apply_action(out_action_a, wave_out_a);
      end
      if (force_b || match_b) begin
        wave_out_b <= apply_action(out_action_b, wave_out_b);
      end
    end else begin
      if (match_a) begin
        wave_out_a <= out_action_a[0] ^ count_down;
      end else if (count_up && at_top && !phase_mode) begin
        wave_out_a <= !out_action_a[0];
      end
      if (match_b) begin
        wave_out_b <= out_action_b[0] ^ count_down;
      end else if (count_up && at_top && !phase_mode) begin
        wave_out_b <= !out_action_b[0];
      end
    end
  end
  assign wave_en_a = (out_action_a != OA_OFF);
  assign wave_en_b = (out_action_b != OA_OFF);

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= RST_REG;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL_A: reg_rdata <= {timer_control_a[7:4], 2'b00, timer_control_a[1:0]};
        OFS_CTRL_B: reg_rdata <= {4'h0, wave_mode_msb, clock_source_sel};
        OFS_COUNT: reg_rdata <= timer_count_value;
        OFS_CMP_A: reg_rdata <= compare_value_a;
        OFS_CMP_B: reg_rdata <= compare_value_b;
        OFS_IRQ_EN: reg_rdata <= {5'h00, timer_irq_enable};
        OFS_IRQ_PEND: reg_rdata <= {5'h00, timer_irq_pending};
        default: reg_rdata <= RST_REG;
      endcase
    end else begin
      reg_rdata <= RST_REG;
    end
  end

  // Checks
  a_force_no_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    force_a && !match_a && !ovf_evt && !timer_irq_pending[1] && irq_ack == 3'b000 |=> !timer_irq_pending[1])
    else $error("forced compare set flag");
  a_pwm_force_ign: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ctrl_b && pwm_mode |-> !force_a && !force_b)
    else $error("force honoured in pwm");
  a_force_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
    force_a && out_action_a == OA_TOGGLE |=> wave_out_a != $past(wave_out_a))
    else $error("force toggle missed");
  a_fb_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFS_CTRL_B |=> reg_rdata[7:4] == 4'h0)
    else $error("control b high bits nonzero");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && (reg_addr == OFS_IRQ_EN || reg_addr == OFS_IRQ_PEND) |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved irq bits nonzero");
  a_stop_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    clock_source_sel == CS_STOP && !wr_count |=> $stable(timer_count_value))
    else $error("counter moved while stopped");
  a_cnt_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_count |=> timer_count_value == $past(reg_wdata))
    else $error("counter write lost");
  a_block_match: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_count ##1 count_up |-> !match_a && !match_b)
    else $error("match not blocked");
  a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    match_b |=> timer_irq_pending[2])
    else $error("compare b flag not set");
  a_flag_a_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    match_a |=> timer_irq_pending[1])
    else $error("compare a flag not set");
  a_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_pend && reg_wdata[0] && !ovf_evt |=> !timer_irq_pending[0])
    else $error("write one did not clear");
  a_ack_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq_ack[1] && !match_a |=> !timer_irq_pending[1])
    else $error("ack did not clear");
  a_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq_req[0] |-> cpu_global_irq_en && timer_irq_enable[0] && timer_irq_pending[0])
    else $error("irq without enable");
  a_ovf_normal: assert property (@(posedge core_clk) disable iff (!rst_n)
    count_up && !wr_count && wave_mode_sel == WM_NORMAL && timer_count_value == CNT_MAX |=> timer_irq_pending[0])
    else $error("overflow flag missed");

  // Force leaves the counter alone, clears act per channel, read bus idles at zero
  a_force_no_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
    force_a && !count_up && !wr_count |=> $stable(timer_count_value))
    else $error("forced compare moved counter");
  a_ack_b_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq_ack[2] && !match_b |=> !timer_irq_pending[2])
    else $error("ack b did not clear");
  a_w1c_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_pend && reg_wdata[1] && !match_a |=> !timer_irq_pending[1])
    else $error("write one did not clear a");
  a_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");

  c_force_a: cover property (@(posedge core_clk) force_a);
  c_block_tick: cover property (@(posedge core_clk) wr_count ##1 count_up);
  c_match_b: cover property (@(posedge core_clk) match_b);
  c_overflow: cover property (@(posedge core_clk) ovf_evt);
  c_ext_rise: cover property (@(posedge core_clk) clock_source_sel == CS_EXT_RISE && count_up);

endmodule : tmr_ctrl
`default_nettype wire

//--- tmr_ctrl_tb.sv
/*
  Self-checking bench for the 8-bit timer control block: register access,
  clock select, compare and overflow flags, requests and force strobes.
  Assumes tmr_pkg and tmr_ctrl are compiled first; assertions live in the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench
  import tmr_pkg::*;
;
  // Design ports
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_count_clock_pin = 1'b0;
  logic cpu_global_irq_en = 1'b0;
  logic [2:0] irq_ack = 3'h0;
  logic [2:0] irq_req;
  logic wave_out_a;
  logic wave_out_b;
  logic wave_en_a;
  logic wave_en_b;
  // Bench state
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h7a38cd58;
  int n;
  logic [7:0] d;
  logic [7:0] v;
  logic [7:0] q;
  logic [3:0] acts = 4'h0;
  logic msb = 1'b0;
  logic ob;
  logic [1:0] seq [5] = '{OA_SET, OA_CLEAR, OA_TOGGLE, OA_TOGGLE, OA_OFF};
  int div [6] = '{1, 1, 8, 64, 256, 1024};
  logic [2:0] pwm [4] = '{WM_PC_FF, WM_FAST_FF, WM_PC_TOPA, WM_FAST_TOPA};

  tmr_ctrl tmr_ctrl_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_count_clock_pin(ext_count_clock_pin), .cpu_global_irq_en(cpu_global_irq_en),
    .irq_ack(irq_ack), .irq_req(irq_req), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .wave_en_a(wave_en_a), .wave_en_b(wave_en_b)
  );

  // Clock at 10 MHz
  always #50 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read strobe, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    r = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
    logic [7:0] r;
    rd(a, r);
    `CHK(nm, e, r & m)
  endtask : rdc

  task automatic setb(input logic [1:0] f, input logic [2:0] cs);
    wr(OFS_CTRL_B, {f, 2'b00, msb, cs});
  endtask : setb

  task automatic set_mode(input logic [2:0] m);
    msb = m[2];
    wr(OFS_CTRL_A, {acts, 2'b00, m[1:0]});
    setb(2'b00, CS_STOP);
  endtask : set_mode

  // Run undivided for c cycles between strobes (c + 2 ticks), then stop
  task automatic run(input int c);
    setb(2'b00, CS_DIV1);
    repeat (c) @(posedge core_clk);
    setb(2'b00, CS_STOP);
  endtask : run

  task automatic ovf_chk(input logic [2:0] m, input logic [7:0] s, input int n1, input int n2);
    set_mode(m);
    wr(OFS_COUNT, s);
    wr(OFS_IRQ_PEND, 8'h07);
    run(n1);
    rdc(OFS_IRQ_PEND, 8'h00, 8'h01, "overflow early");
    run(n2);
    rdc(OFS_IRQ_PEND, 8'h01, 8'h01, "overflow set");
  endtask : ovf_chk

  task automatic ack(input logic [2:0] m);
    @(posedge core_clk);
    irq_ack <= m;
    @(posedge core_clk);
    irq_ack <= 3'h0;
  endtask : ack

  task automatic req_chk(input logic [2:0] e);
    @(negedge core_clk);
    `CHK("irq request", e, irq_req)
  endtask : req_chk

  function automatic logic next_out(input logic [1:0] act, input logic cur);
    case (act)
      OA_TOGGLE: return ~cur;
      OA_CLEAR: return 1'b0;
      OA_SET: return 1'b1;
      default: return cur;
    endcase
  endfunction : next_out

  // Main sequence
  initial begin
    do_reset();
    for (int a = 0; a < 8; a++) begin
      rdc(a[2:0], RST_REG, 8'hff, "reset value");
    end
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      wr(OFS_CMP_A, v);
      rdc(OFS_CMP_A, v, 8'hff, "compare a");
      wr(OFS_CMP_B, ~v);
      rdc(OFS_CMP_B, ~v, 8'hff, "compare b");
      wr(OFS_COUNT, v);
      wr(3'h7, ~v);
      rdc(OFS_COUNT, v, 8'hff, "count");
      wr(OFS_IRQ_EN, v);
      rdc(OFS_IRQ_EN, v & 8'h07, 8'hff, "irq enable");
      wr(OFS_IRQ_PEND, v);
      rdc(OFS_IRQ_PEND, 8'h00, 8'hff, "pending");
      wr(OFS_CTRL_B, {v[7:3], CS_STOP});
      rdc(OFS_CTRL_B, {4'h0, v[3], 3'h0}, 8'hff, "control b");
    end
    set_mode(WM_NORMAL);
    wr(OFS_IRQ_EN, 8'h00);
    repeat (20) @(posedge core_clk);
    rdc(3'h7, 8'h00, 8'hff, "unmapped");
    rdc(OFS_COUNT, v, 8'hff, "stopped count");
    // Tick rate of each internal source over a whole number of prescaler periods
    for (int c = 1; c < 6; c++) begin
      n = (c == 1) ? 100 : 1024;
      setb(2'b00, c[2:0]);
      rd(OFS_COUNT, d);
      repeat (n - 2) @(posedge core_clk);
      rd(OFS_COUNT, v);
      q = v - d;
      `CHK("tick rate", 8'(n / div[c]), q)
    end
    // External pin, both edges
    for (int c = 6; c < 8; c++) begin
      setb(2'b00, c[2:0]);
      repeat (4) @(posedge core_clk);
      rd(OFS_COUNT, d);
      n = 1 + ($random(seed) & 15);
      repeat (n) begin
        repeat (5) @(posedge core_clk);
        ext_count_clock_pin <= 1'b1;
        repeat (5) @(posedge core_clk);
        ext_count_clock_pin <= 1'b0;
      end
      repeat (6) @(posedge core_clk);
      rd(OFS_COUNT, v);
      q = v - d;
      `CHK("pin edges", n[7:0], q)
    end
    // Compare and overflow flags, requests, acknowledge and write-one clear
    wr(OFS_CMP_A, 8'hf8);
    wr(OFS_CMP_B, 8'hfa);
    ovf_chk(WM_NORMAL, 8'hf0, 2, 30);
    rdc(OFS_IRQ_PEND, 8'h07, 8'hff, "match flags");
    wr(OFS_IRQ_EN, 8'h07);
    cpu_global_irq_en <= 1'b1;
    req_chk(3'b111);
    wr(OFS_IRQ_EN, 8'h02);
    req_chk(3'b010);
    cpu_global_irq_en <= 1'b0;
    req_chk(3'b000);
    cpu_global_irq_en <= 1'b1;
    wr(OFS_IRQ_EN, 8'h07);
    ack(3'b001);
    rdc(OFS_IRQ_PEND, 8'h06, 8'hff, "ack overflow");
    req_chk(3'b110);
    wr(OFS_IRQ_PEND, 8'h00);
    rdc(OFS_IRQ_PEND, 8'h06, 8'hff, "write zero");
    wr(OFS_IRQ_PEND, 8'h04);
    rdc(OFS_IRQ_PEND, 8'h02, 8'hff, "write one");
    ack(3'b010);
    rdc(OFS_IRQ_PEND, 8'h00, 8'hff, "ack match a");
    // Counter write blocks the match on the next tick, on both channels
    wr(OFS_CMP_A, 8'h40);
    wr(OFS_CMP_B, 8'h40);
    wr(OFS_COUNT, 8'h30);
    setb(2'b00, CS_DIV1);
    wr(OFS_COUNT, 8'h40);
    repeat (8) @(posedge core_clk);
    setb(2'b00, CS_STOP);
    rdc(OFS_IRQ_PEND, 8'h00, 8'hff, "blocked match");
    setb(2'b00, CS_DIV1);
    wr(OFS_COUNT, 8'h3e);
    repeat (8) @(posedge core_clk);
    setb(2'b00, CS_STOP);
    rdc(OFS_IRQ_PEND, 8'h06, 8'hff, "passing match");
    // Forced compare in clear-on-match mode, each action on each channel
    wr(OFS_COUNT, 8'h55);
    wr(OFS_IRQ_PEND, 8'h07);
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 5; k++) begin
        acts = (ch == 0) ? {seq[k], 2'b00} : {2'b00, seq[k]};
        set_mode(WM_CTC);
        setb((ch == 0) ? 2'b10 : 2'b01, CS_STOP);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        ob = next_out(seq[k], ob);
        `CHK("out enable", seq[k] != OA_OFF, (ch == 0) ? wave_en_a : wave_en_b)
        if (seq[k] != OA_OFF) `CHK("forced out", ob, (ch == 0) ? wave_out_a : wave_out_b)
      end
    end
    rdc(OFS_COUNT, 8'h55, 8'hff, "count after force");
    rdc(OFS_IRQ_PEND, 8'h00, 8'hff, "flags after force");
    // Force strobes ignored in every PWM mode
    acts = 4'hf;
    for (int i = 0; i < 4; i++) begin
      set_mode(pwm[i]);
      setb(2'b11, CS_STOP);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("pwm force", 2'b00, {wave_out_a, wave_out_b})
    end
    // Overflow position per waveform mode other than WM_PC_TOPA
    acts = 4'h0;
    ovf_chk(WM_CTC, 8'hf0, 2, 30);
    ovf_chk(WM_FAST_FF, 8'hf0, 2, 30);
    wr(OFS_CMP_A, 8'h30);
    ovf_chk(WM_FAST_TOPA, 8'h10, 8, 30);
    do_reset();
    ovf_chk(WM_PC_FF, 8'h10, 300, 250);
    finish_test();
  end
endmodule : testbench
`default_nettype wire

//--- tmr_pkg.sv
/*
  Shared constants for the 8-bit timer control block: register offsets,
  field positions, reset values, clock-select and waveform-mode codes.
  Assumes a simple strobe register port with byte-wide registers.
*/
`default_nettype none
package tmr_pkg;
  // Register offsets (byte addresses)
  localparam logic [2:0] OFS_CTRL_A = 3'h0;
  localparam logic [2:0] OFS_CTRL_B = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_CMP_A = 3'h3;
  localparam logic [2:0] OFS_CMP_B = 3'h4;
  localparam logic [2:0] OFS_IRQ_EN = 3'h5;
  localparam logic [2:0] OFS_IRQ_PEND = 3'h6;
  // Control B field positions
  localparam int FOC_A_BIT = 7;
  localparam int FOC_B_BIT = 6;
  localparam int WGM_MSB_BIT = 3;
  // Control A field positions
  localparam int OUTA_LSB = 6;
  localparam int OUTB_LSB = 4;
  // Irq bit positions
  localparam int IRQ_CMPB_BIT = 2;
  localparam int IRQ_CMPA_BIT = 1;
  localparam int IRQ_OVF_BIT = 0;
  // Reset value and counter bounds
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // Clock-select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Waveform modes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_TOPA = 3'h5;
  localparam logic [2:0] WM_FAST_TOPA = 3'h7;
  // Output action codes
  localparam logic [1:0] OA_OFF = 2'h0;
  localparam logic [1:0] OA_TOGGLE = 2'h1;
  localparam logic [1:0] OA_CLEAR = 2'h2;
  localparam logic [1:0] OA_SET = 2'h3;
  // Prescaler width (counts to 1023)
  localparam int PRE_W = 10;
endpackage : tmr_pkg
`default_nettype wire
